// >>> pkg/dbg_watch_defines.svh
`ifndef DBG_WATCH_DEFINES_SVH
`define DBG_WATCH_DEFINES_SVH

// status bit positions
`define STAT_DEBUG_BIT     7
`define STAT_HALT_BIT      6
`define STAT_PROTECT_BIT   5
// control bit positions
`define CTL_WRITE_BIT      7
`define CTL_READ_BIT       6
`define CTL_DMATCH_BIT     5
`define CTL_RSVD_BIT       4
`define CTL_HIGH_MSB       3
// reset values, reserved status bits and acknowledge character
`define CTL_RESET          8'h00
`define ADDR_RESET         8'h00
`define DATA_RESET         8'h00
`define STAT_RESERVED      5'h00
`define STAT_RESET         8'h00
`define ACK_CHAR           8'hff

`endif

// >>> pkg/dbg_watch_pkg.sv
package dbg_watch_pkg;
  typedef logic [11:0] rf_addr_t;
  typedef logic [7:0]  byte_t;
endpackage

// >>> logic/debug_watchpoint_status.sv
`timescale 1ns/1ps
`include "dbg_watch_defines.svh"

// How it works
// - status bit 7 shows debug mode
// - status bit 6 shows processor halted
// - status bit 5 reports read protection
// - status bits 4..0 zero, register read-only
// - write-break enable breaks on watched writes
// - read-break enable breaks on watched reads
// - enables refuse setting under read protection
// - data-match requires data equal match value
// - data-match needs read or write enable
// - watched address is control[3:0] plus low
// - a break pulses debug_break; the debugger sets its mode bit
// - acknowledge character sent when enabled
// - watch write outside debug clears control
module debug_watchpoint_status
  import dbg_watch_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  cpu_halted,
  input  wire logic  read_protect_flag,
  input  wire logic  debug_entry_control,
  input  wire logic  break_acknowledge_enable,
  input  wire logic  watch_write,
  input  wire byte_t wr_control,
  input  wire byte_t wr_low_address,
  input  wire byte_t wr_match_value,
  input  wire logic  rf_valid,
  input  wire logic  rf_write,
  input  wire rf_addr_t rf_addr,
  input  wire byte_t rf_data,
  output byte_t      debugger_state_flags,
  output byte_t      watch_control_and_high_address,
  output byte_t      watch_low_address,
  output byte_t      watch_match_value,
  output logic       debug_break,
  output logic       ack_send,
  output byte_t      ack_char
);

  // ----------------------------------------
  // read protection
  // ----------------------------------------
  logic  protect_on;

  // option is stored active low: zero means protected
  assign protect_on = ~read_protect_flag;

  // ----------------------------------------
  // watch write command
  // ----------------------------------------
  logic  cmd_accept;
  logic  cmd_reject;

  // refused outside debug mode or under protection
  assign cmd_reject = watch_write && (!debug_entry_control || protect_on);
  assign cmd_accept = watch_write && !cmd_reject;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  byte_t ctl_r;
  byte_t ctl_nxt;

  always_comb
  begin
    ctl_nxt = ctl_r;
    if (cmd_reject)
    begin
      ctl_nxt = `CTL_RESET;
    end
    else if (cmd_accept)
    begin
      ctl_nxt = wr_control;
      // bit 4 kept as written; host must send zero
      ctl_nxt[`CTL_RSVD_BIT] = wr_control[`CTL_RSVD_BIT];
    end
    // protection also drops enables set before it came on
    if (protect_on)
    begin
      ctl_nxt[`CTL_WRITE_BIT]  = 1'b0;
      ctl_nxt[`CTL_READ_BIT]   = 1'b0;
      ctl_nxt[`CTL_DMATCH_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r <= `CTL_RESET;
    end
    else
    begin
      ctl_r <= ctl_nxt;
    end
  end

  assign watch_control_and_high_address = ctl_r;

  // ----------------------------------------
  // low address register
  // ----------------------------------------
  byte_t addr_r;
  byte_t addr_nxt;

  // address and data load even when control is refused
  always_comb
  begin
    addr_nxt = addr_r;
    if (watch_write)
    begin
      addr_nxt = wr_low_address;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_r <= `ADDR_RESET;
    end
    else
    begin
      addr_r <= addr_nxt;
    end
  end

  assign watch_low_address = addr_r;

  // ----------------------------------------
  // match value register
  // ----------------------------------------
  byte_t data_r;
  byte_t data_nxt;

  always_comb
  begin
    data_nxt = data_r;
    if (watch_write)
    begin
      data_nxt = wr_match_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_r <= `DATA_RESET;
    end
    else
    begin
      data_r <= data_nxt;
    end
  end

  assign watch_match_value = data_r;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  logic       wr_break_en;
  logic       rd_break_en;
  logic       dmatch_en;
  logic [3:0] high_addr;
  rf_addr_t   watched;

  assign wr_break_en = ctl_r[`CTL_WRITE_BIT];
  assign rd_break_en = ctl_r[`CTL_READ_BIT];
  assign dmatch_en   = ctl_r[`CTL_DMATCH_BIT];
  assign high_addr   = ctl_r[`CTL_HIGH_MSB:0];
  assign watched     = {high_addr, addr_r};

  // ----------------------------------------
  // address compare
  // ----------------------------------------
  logic [11:0] addr_eq;
  genvar       ai;

  // bitwise compare; all bits must agree in this cycle
  generate
    for (ai = 0; ai < 12; ai++)
    begin : g_addr_eq
      assign addr_eq[ai] = ~(rf_addr[ai] ^ watched[ai]);
    end
  endgenerate

  // ----------------------------------------
  // data compare
  // ----------------------------------------
  logic [7:0] data_eq;
  genvar      di;

  generate
    for (di = 0; di < 8; di++)
    begin : g_data_eq
      assign data_eq[di] = ~(rf_data[di] ^ data_r[di]);
    end
  endgenerate

  // ----------------------------------------
  // break qualification
  // ----------------------------------------
  logic hit;
  logic dir_ok;
  logic data_ok;
  logic brk_nxt;
  logic brk_r;

  always_comb
  begin
    hit     = rf_valid && (&addr_eq);
    dir_ok  = (rf_write && wr_break_en)
           || (!rf_write && rd_break_en);
    // data match only narrows an already enabled direction
    data_ok = !dmatch_en || (&data_eq);
    brk_nxt = hit && dir_ok && data_ok;
  end

  // registered so the break never glitches on address ripple
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brk_r <= 1'b0;
    end
    else
    begin
      brk_r <= brk_nxt;
    end
  end

  // ----------------------------------------
  // break and acknowledge outputs
  // ----------------------------------------
  // one-cycle pulse; debugger sets its mode bit from it
  assign debug_break = brk_r;
  assign ack_send    = brk_r && break_acknowledge_enable;
  assign ack_char    = `ACK_CHAR;

  // ----------------------------------------
  // status
  // ----------------------------------------
  logic  stat_debug;
  logic  stat_halt;
  logic  stat_protect;
  byte_t stat_r;
  byte_t stat_nxt;

  assign stat_debug   = debug_entry_control;
  assign stat_halt    = cpu_halted;
  assign stat_protect = protect_on;

  // one cycle behind its sources; host reads are far slower
  always_comb
  begin
    stat_nxt = {stat_debug,
                stat_halt,
                stat_protect,
                `STAT_RESERVED};
  end

  // no write path exists, so the register is read-only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_r <= `STAT_RESET;
    end
    else
    begin
      stat_r <= stat_nxt;
    end
  end

  assign debugger_state_flags = stat_r;

  // ----------------------------------------
  // notes
  // ----------------------------------------
  // limitation: one watchpoint only; a second needs
  // its own registers and compare loops.
  // trade-off: break is one cycle late, but stays
  // clean for the mode bit that latches it.

endmodule

// >>> verif/wp_chk_sva.sv
`timescale 1ns/1ps
module wp_chk
  import dbg_watch_pkg::*;
(
  input wire logic  clk, rst_n, cpu_halted, read_protect_flag, debug_entry_control,
  input wire logic  break_acknowledge_enable, rf_valid, rf_write, debug_break, ack_send,
  input wire byte_t debugger_state_flags, watch_control_and_high_address, rf_data,
  input wire byte_t watch_low_address, watch_match_value, ack_char,
  input wire rf_addr_t rf_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire byte_t c = watch_control_and_high_address;
  wire logic hit = rf_valid && (rf_write ? c[7] : c[6]) && rf_addr == {c[3:0], watch_low_address}
    && (!c[5] || rf_data == watch_match_value);
  a_stat_debug: assert property (##1 debugger_state_flags[7] == $past(debug_entry_control))
    else $error("debug flag wrong");
  a_stat_halt: assert property (##1 debugger_state_flags[6] == $past(cpu_halted))
    else $error("halt flag wrong");
  a_stat_prot: assert property (##1 debugger_state_flags[5] == !$past(read_protect_flag))
    else $error("protect flag wrong");
  a_stat_rsvd: assert property (debugger_state_flags[4:0] == 5'h00)
    else $error("reserved bits set");
  a_prot_lock: assert property (!read_protect_flag |=> c[7:5] == 3'h0)
    else $error("enable set under protection");
  a_break_cause: assert property (debug_break |-> $past(hit))
    else $error("break without match");
  a_break_hit: assert property (hit |=> debug_break)
    else $error("match without break");
  a_ack_follow: assert property (ack_send == (debug_break && break_acknowledge_enable))
    else $error("ack wrong");
  a_ack_char: assert property (ack_char == 8'hff)
    else $error("ack char wrong");
  cover property (debug_break);
  cover property (ack_send);
  cover property (!read_protect_flag && c == 8'h00);
endmodule
bind debug_watchpoint_status wp_chk chk (.*);

// >>> verif/dbg_host.sv
`timescale 1ns/1ps
module dbg_host
  import dbg_watch_pkg::*;
(
  input wire logic clk,
  output logic     watch_write,
  output byte_t    wr_control, wr_low_address, wr_match_value
);
  initial watch_write = 1'b0;
  // one watch write command, three bytes
  task put(input byte_t c, a, d);
    @(negedge clk);
    watch_write = 1'b1;
    wr_control = c & 8'hef;
    {wr_low_address, wr_match_value} = {a, d};
    @(negedge clk);
    watch_write = 1'b0;
  endtask
endmodule

// >>> verif/test_debug_watchpoint_status.sv
`timescale 1ns/1ps
module test_debug_watchpoint_status
  import dbg_watch_pkg::*;
;
  logic clk = 0, rst_n = 0, cpu_halted = 0, read_protect_flag = 1, debug_entry_control = 0;
  logic break_acknowledge_enable = 0, rf_valid = 0, rf_write = 0, watch_write;
  logic debug_break, ack_send;
  byte_t wr_control, wr_low_address, wr_match_value, rf_data = 0, debugger_state_flags;
  byte_t watch_control_and_high_address, watch_low_address, watch_match_value, ack_char;
  rf_addr_t rf_addr = 0;
  int n_errors = 0, total_checks = 0, cyc = 0;
  debug_watchpoint_status dut (.*);
  dbg_host h (.*);
  always #20 clk = ~clk;
  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 2000) begin n_errors++; conclude; end
  task chk(input byte_t g, e);
    total_checks++;
    if (g !== e) begin n_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end
  endtask
  // access taken at the next rising edge, which also registers the break; checked at the falling edge after it
  task acc(input logic w, input rf_addr_t a, input byte_t d, input logic e);
    @(negedge clk);
    {rf_valid, rf_write, rf_addr, rf_data} = {1'b1, w, a, d};
    @(negedge clk);
    rf_valid = 0;
    chk({7'h0, debug_break}, {7'h0, e});
    chk({7'h0, ack_send}, {7'h0, e && break_acknowledge_enable});
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    chk(debugger_state_flags, 8'h00); chk(watch_control_and_high_address, 8'h00);
    {debug_entry_control, cpu_halted, read_protect_flag} = 3'b110;
    repeat (2) @(negedge clk);
    chk(debugger_state_flags, 8'he0);
    {cpu_halted, read_protect_flag} = 2'b01;
    h.put(8'hc5, 8'h3a, 8'h77);
    chk(debugger_state_flags, 8'h80); chk(watch_control_and_high_address, 8'hc5);
    acc(1, 12'h53a, 8'h00, 1); acc(0, 12'h53a, 8'h01, 1);
    acc(1, 12'h43a, 8'h00, 0); acc(0, 12'h53b, 8'h00, 0);
    break_acknowledge_enable = 1;
    h.put(8'h65, 8'h3a, 8'h77);
    acc(0, 12'h53a, 8'h77, 1); acc(0, 12'h53a, 8'h76, 0);
    acc(1, 12'h53a, 8'h77, 0);
    h.put(8'h25, 8'h3a, 8'h77);
    acc(1, 12'h53a, 8'h77, 0);
    read_protect_flag = 0;
    h.put(8'he5, 8'h3a, 8'h77);
    chk(watch_control_and_high_address, 8'h00);
    {read_protect_flag, debug_entry_control} = 2'b10;
    h.put(8'hc5, 8'h3a, 8'h77);
    chk(watch_control_and_high_address, 8'h00); chk(watch_low_address, 8'h3a);
    chk(watch_match_value, 8'h77);
    chk(ack_char, 8'hff);
    conclude;
  end
endmodule
